/* File: rtl/ufx_front.sv */
/*
 * USB function front end: endpoint pipe addressing, transceiver control
 * and status, and the indirect address/data port into the core registers.
 * Assumes the processor's SFR bus on clk (one-cycle write and read
 * strobes), and a core register file that answers a read strobe with
 * data a fixed number of cycles later.
 */
`timescale 1ns/1ps
`default_nettype none
module ufx_front
    import ufx_pkg::*;
#(
    parameter int READ_CYCLES = ufx_pkg::UFX_READ_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // SFR bus from the processor
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Core register file port
    output logic      [5:0] core_addr,
    output logic            core_wr,
    output logic            core_rd,
    output logic      [7:0] core_wdata,
    input  wire logic [7:0] core_rdata,
    // Endpoint targeting for indexed registers
    output logic      [3:0] endpoint_select,
    output logic      [3:0] endpoint_target_onehot,
    // Transceiver pins and controls
    input  wire logic       vbus_present,
    input  wire logic       dplus_in,
    input  wire logic       dminus_in,
    output logic            dplus_out,
    output logic            dplus_oe,
    output logic            dminus_out,
    output logic            dminus_oe,
    output logic            pullup_dplus,
    output logic            pullup_dminus,
    output logic            phy_enable,
    output logic            full_speed
);
    import ufx_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UFX_IDLE = 2'b00,
        UFX_WAIT = 2'b01,
        UFX_DONE = 2'b11
    } ufx_state_t;

    ufx_state_t state, next_state;
    logic [7:0] xcvr_ctl, next_xcvr_ctl;
    logic [5:0] core_register_select, next_core_register_select;
    logic       auto_read_enable, next_auto_read_enable;
    logic       busy, next_busy;
    logic [7:0] indirect_data, next_indirect_data;
    logic [3:0] ep_sel, next_ep_sel;
    logic [7:0] wait_cnt, next_wait_cnt;
    logic [7:0] next_sfr_rdata;
    logic [5:0] next_core_addr;
    logic       next_core_wr, next_core_rd;
    logic [7:0] next_core_wdata;
    logic [1:0] pins_sync;
    logic       diff_receiver_state, dplus_level, dminus_level;

    // Pin levels cross into clk through two flip-flops
    ufx_sync #(.WIDTH(2)) u_sync (
        .clk      (clk),
        .rstn     (rstn),
        .async_in ({dplus_in, dminus_in}),
        .sync_out (pins_sync)
    );

    // Differential state decoded after the flops, so no raw pin logic
    assign dplus_level         = pins_sync[1];
    assign dminus_level        = pins_sync[0];
    assign diff_receiver_state = dplus_level & ~dminus_level
                                 & xcvr_ctl[UFX_BIT_PHY_ENABLE_BIT];

    // Endpoint select is valid only for endpoints zero to three
    function automatic logic ep_valid(input logic [3:0] sel);
        ep_valid = (sel <= UFX_EP_LAST);
    endfunction

    // ------------------------------------------------------------
    // Register file and indirect port, next values
    // ------------------------------------------------------------
    always_comb
    begin
        next_state                = state;
        next_xcvr_ctl             = xcvr_ctl;
        next_core_register_select = core_register_select;
        next_auto_read_enable     = auto_read_enable;
        next_busy                 = busy;
        next_indirect_data        = indirect_data;
        next_ep_sel               = ep_sel;
        next_wait_cnt             = wait_cnt;
        next_core_addr            = core_register_select;
        next_core_wr              = 1'b0;
        next_core_rd              = 1'b0;
        next_core_wdata           = core_wdata;
        next_sfr_rdata            = sfr_rdata;

        // Processor writes
        if (sfr_wr)
        begin
            case (sfr_addr)
                UFX_SFR_XCVR:
                begin
                    next_xcvr_ctl[UFX_BIT_PULLUP_ENABLE_BIT:UFX_BIT_TST_LO] =
                        sfr_wdata[UFX_BIT_PULLUP_ENABLE_BIT:UFX_BIT_TST_LO];
                end
                UFX_SFR_ADDR:
                begin
                    next_core_register_select = sfr_wdata[5:0];
                    next_auto_read_enable     = sfr_wdata[UFX_BIT_AUTO_READ_ENABLE];
                    if (sfr_wdata[UFX_BIT_BUSY] && !busy)
                    begin
                        next_busy  = 1'b1;
                        next_state = UFX_WAIT;
                    end
                end
                UFX_SFR_DATA:
                begin
                    next_indirect_data = sfr_wdata;
                    next_core_wr       = 1'b1;
                    next_core_wdata    = sfr_wdata;
                    // Endpoint index is held locally as well
                    if (core_register_select == UFX_CORE_INDEX)
                        next_ep_sel = sfr_wdata[3:0];
                end
                default:
                begin
                end
            endcase
        end

        // Processor reads; data register read may chain the next read
        if (sfr_rd)
        begin
            case (sfr_addr)
                UFX_SFR_XCVR: next_sfr_rdata = {xcvr_ctl[7:3], diff_receiver_state,
                                                dplus_level, dminus_level};
                UFX_SFR_ADDR: next_sfr_rdata = {busy, auto_read_enable,
                                                core_register_select};
                UFX_SFR_DATA:
                begin
                    next_sfr_rdata = indirect_data;
                    if (auto_read_enable && !busy)
                    begin
                        next_busy  = 1'b1;
                        next_state = UFX_WAIT;
                    end
                end
                default:      next_sfr_rdata = UFX_RESET_BYTE;
            endcase
        end

        // Indirect read sequencing
        case (state)
            UFX_IDLE:
            begin
                next_wait_cnt = 8'h00;
            end
            UFX_WAIT:
            begin
                if (wait_cnt == 8'h00)
                    next_core_rd = 1'b1;
                if (wait_cnt == 8'(READ_CYCLES))
                    next_state = UFX_DONE;
                else
                    next_wait_cnt = wait_cnt + 8'h01;
            end
            UFX_DONE:
            begin
                // Core register value lands, busy drops in the same cycle
                if (core_register_select == UFX_CORE_INDEX)
                    next_indirect_data = {4'h0, ep_sel};
                else
                    next_indirect_data = core_rdata;
                next_busy  = 1'b0;
                next_state = UFX_IDLE;
            end
            default:
            begin
                next_state = UFX_IDLE;
            end
        endcase
    end

    // Register update
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state                <= UFX_IDLE;
            xcvr_ctl             <= UFX_RESET_BYTE;
            core_register_select <= 6'h00;
            auto_read_enable     <= 1'b0;
            busy                 <= 1'b0;
            indirect_data        <= UFX_RESET_BYTE;
            ep_sel               <= UFX_EP_NONE;
            wait_cnt             <= 8'h00;
            sfr_rdata            <= UFX_RESET_BYTE;
            core_addr            <= 6'h00;
            core_wr              <= 1'b0;
            core_rd              <= 1'b0;
            core_wdata           <= UFX_RESET_BYTE;
        end
        else
        begin
            state                <= next_state;
            xcvr_ctl             <= next_xcvr_ctl;
            core_register_select <= next_core_register_select;
            auto_read_enable     <= next_auto_read_enable;
            busy                 <= next_busy;
            indirect_data        <= next_indirect_data;
            ep_sel               <= next_ep_sel;
            wait_cnt             <= next_wait_cnt;
            sfr_rdata            <= next_sfr_rdata;
            core_addr            <= next_core_addr;
            core_wr              <= next_core_wr;
            core_rd              <= next_core_rd;
            core_wdata           <= next_core_wdata;
        end
    end

    // ------------------------------------------------------------
    // Transceiver and endpoint outputs
    // ------------------------------------------------------------
    logic       n_pu_dp, n_pu_dm, n_dp, n_dm, n_oe;
    logic [3:0] n_onehot;

    // Pull-up placement, forced test levels, endpoint decode
    always_comb
    begin
        n_pu_dp  = xcvr_ctl[UFX_BIT_PULLUP_ENABLE_BIT] & vbus_present & xcvr_ctl[UFX_BIT_SPEED];
        n_pu_dm  = xcvr_ctl[UFX_BIT_PULLUP_ENABLE_BIT] & vbus_present & ~xcvr_ctl[UFX_BIT_SPEED];
        n_oe     = 1'b1;
        n_dp     = 1'b0;
        n_dm     = 1'b0;
        case (ufx_test_t'(xcvr_ctl[UFX_BIT_TST_HI:UFX_BIT_TST_LO]))
            UFX_TST_DIFF1: n_dp = 1'b1;
            UFX_TST_DIFF0: n_dm = 1'b1;
            UFX_TST_SE0:   n_dp = 1'b0;
            default:       n_oe = 1'b0;
        endcase
        // Suspended transceiver drives nothing
        if (!xcvr_ctl[UFX_BIT_PHY_ENABLE_BIT])
            n_oe = 1'b0;
        // Endpoints zero to three each set one target bit; others set none
        n_onehot = 4'h0;
        if (ep_valid(ep_sel))
            n_onehot[ep_sel[1:0]] = 1'b1;
    end

    // Outputs straight from flip-flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pullup_dplus           <= 1'b0;
            pullup_dminus          <= 1'b0;
            dplus_out              <= 1'b0;
            dminus_out             <= 1'b0;
            dplus_oe               <= 1'b0;
            dminus_oe              <= 1'b0;
            phy_enable             <= 1'b0;
            full_speed             <= 1'b0;
            endpoint_select        <= UFX_EP_NONE;
            endpoint_target_onehot <= 4'h0;
        end
        else
        begin
            pullup_dplus           <= n_pu_dp;
            pullup_dminus          <= n_pu_dm;
            dplus_out              <= n_dp;
            dminus_out             <= n_dm;
            dplus_oe               <= n_oe;
            dminus_oe              <= n_oe;
            phy_enable             <= xcvr_ctl[UFX_BIT_PHY_ENABLE_BIT];
            full_speed             <= xcvr_ctl[UFX_BIT_SPEED];
            endpoint_select        <= ep_sel;
            endpoint_target_onehot <= n_onehot;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ufx_pkg.sv */
/*
 * Package for the USB function front end: register offsets, field
 * positions, reset values, test modes and timing constants.
 * Assumes an 8-bit special function register bus on one 50 MHz clock.
 */
package ufx_pkg;
    // ------------------------------------------------------------
    // Special function register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] UFX_SFR_ADDR = 8'h96;
    localparam logic [7:0] UFX_SFR_DATA = 8'h97;
    localparam logic [7:0] UFX_SFR_XCVR = 8'hD7;

    // ------------------------------------------------------------
    // Core register offsets reached through the indirect port
    // ------------------------------------------------------------
    localparam logic [5:0] UFX_CORE_INDEX = 6'h0F;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int UFX_BIT_BUSY    = 7;
    localparam int UFX_BIT_AUTO_READ_ENABLE  = 6;
    localparam int UFX_BIT_PULLUP_ENABLE_BIT    = 7;
    localparam int UFX_BIT_PHY_ENABLE_BIT   = 6;
    localparam int UFX_BIT_SPEED   = 5;
    localparam int UFX_BIT_TST_HI  = 4;
    localparam int UFX_BIT_TST_LO  = 3;
    localparam int UFX_BIT_DIFF    = 2;
    localparam int UFX_BIT_DPLUS   = 1;
    localparam int UFX_BIT_DMINUS  = 0;
    localparam logic [7:0] UFX_RESET_BYTE = 8'h00;
    localparam logic [3:0] UFX_EP_LAST    = 4'h3;
    localparam logic [3:0] UFX_EP_NONE    = 4'h0;

    // ------------------------------------------------------------
    // Transceiver test modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UFX_TST_NORMAL = 2'h0,
        UFX_TST_DIFF1  = 2'h1,
        UFX_TST_DIFF0  = 2'h2,
        UFX_TST_SE0    = 2'h3
    } ufx_test_t;

    // ------------------------------------------------------------
    // Indirect read timing
    // ------------------------------------------------------------
    localparam int UFX_CLK_MHZ     = 50;
    localparam int UFX_READ_NS     = 40;
    localparam int UFX_READ_CYCLES = (UFX_READ_NS * UFX_CLK_MHZ + 999) / 1000;
endpackage

/* File: rtl/ufx_sync.sv */
/*
 * Two flip-flop synchroniser for a bundle of asynchronous levels.
 * Assumes the reading logic sits on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ufx_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // Two stages; the first feeds only the second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage1   <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/ufx_front_checker.sv */
/*
 * Port assertions for the USB function front end.
 * Assumes one clock and an asynchronous active-low reset; bound to ufx_front.
 */
`timescale 1ns/1ps
`default_nettype none
module ufx_front_checker
    import ufx_pkg::*;
#(
    parameter int READ_CYCLES = 1
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    // Core port and endpoint targeting
    input  wire logic [5:0] core_addr,
    input  wire logic       core_wr,
    input  wire logic       core_rd,
    input  wire logic [7:0] core_wdata,
    input  wire logic [3:0] endpoint_select,
    input  wire logic [3:0] endpoint_target_onehot,
    // Transceiver
    input  wire logic       vbus_present,
    input  wire logic       dplus_out,
    input  wire logic       dplus_oe,
    input  wire logic       pullup_dplus,
    input  wire logic       pullup_dminus,
    input  wire logic       phy_enable,
    input  wire logic       full_speed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic  xw = sfr_wr && sfr_addr == UFX_SFR_XCVR;
    wire logic  aw = sfr_wr && sfr_addr == UFX_SFR_ADDR;
    wire logic  dw = sfr_wr && sfr_addr == UFX_SFR_DATA;
    logic [7:0] ctl_q;
    logic [7:0] wd_q;
    logic [5:0] adr_q;
    logic [2:0] gap;
    logic [1:0] up;
    // Shadows of the last writes, cycles since a core read, cycles out of reset
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {ctl_q, wd_q, adr_q} <= '0;
            gap <= 3'h7;
            up <= 2'h0;
        end
        else
        begin
            if (xw) ctl_q <= sfr_wdata;
            if (dw) wd_q <= sfr_wdata;
            if (aw) adr_q <= sfr_wdata[5:0];
            gap <= core_rd ? 3'h0 : ((gap == 3'h7) ? gap : gap + 3'h1);
            up <= (up == 2'h3) ? up : up + 2'h1;
        end
    end
    property p_ctl;
        xw ##1 (!xw)[*2] |=> phy_enable == ctl_q[6] && full_speed == ctl_q[5];
    endproperty
    a_ctl: assert property (p_ctl) else $error("phy or speed output wrong");
    property p_pullup;
        (xw && vbus_present) ##1 (!xw && vbus_present)[*2] |=>
            pullup_dplus == (ctl_q[7] && ctl_q[5]) && pullup_dminus == (ctl_q[7] && !ctl_q[5]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up placement wrong");
    property p_detach;
        (!vbus_present)[*3] |-> !pullup_dplus && !pullup_dminus;
    endproperty
    a_detach: assert property (p_detach) else $error("pull-up without supply");
    property p_drive;
        xw ##1 (!xw)[*2] |=> dplus_oe == (ctl_q[6] && ctl_q[4:3] != 2'h0)
            && (!dplus_oe || dplus_out == (ctl_q[4:3] == 2'h1));
    endproperty
    a_drive: assert property (p_drive) else $error("forced drive wrong");
    property p_start;
        aw && sfr_wdata[7] && gap == 3'h7 ##1 !aw |-> ##[0:2] (core_rd && core_addr == adr_q);
    endproperty
    a_start: assert property (p_start) else $error("read not started");
    property p_nostart;
        aw && !sfr_wdata[7] && gap == 3'h7 ##1 (!sfr_rd && !sfr_wr)[*4] |-> gap > 3'h3;
    endproperty
    a_nostart: assert property (p_nostart) else $error("read started by zero");
    property p_cwr;
        dw |-> ##[1:2] (core_wr && core_wdata == wd_q && core_addr == adr_q);
    endproperty
    a_cwr: assert property (p_cwr) else $error("core write wrong");
    property p_index;
        dw && adr_q == UFX_CORE_INDEX ##1 (!sfr_wr)[*3] |-> endpoint_select == wd_q[3:0];
    endproperty
    a_index: assert property (p_index) else $error("endpoint select wrong");
    property p_onehot;
        up == 2'h3 |-> endpoint_target_onehot ==
            ((endpoint_select > UFX_EP_LAST) ? UFX_EP_NONE : 4'h1 << endpoint_select);
    endproperty
    a_onehot: assert property (p_onehot) else $error("endpoint target wrong");
    c_read: cover property (aw && sfr_wdata[7]);
    c_index: cover property (dw && adr_q == UFX_CORE_INDEX);
    c_force: cover property (dplus_oe);
endmodule
bind ufx_front ufx_front_checker #(.READ_CYCLES(READ_CYCLES)) u_chk (
    .clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .core_addr(core_addr), .core_wr(core_wr), .core_rd(core_rd),
    .core_wdata(core_wdata), .endpoint_select(endpoint_select),
    .endpoint_target_onehot(endpoint_target_onehot), .vbus_present(vbus_present),
    .dplus_out(dplus_out), .dplus_oe(dplus_oe), .pullup_dplus(pullup_dplus),
    .pullup_dminus(pullup_dminus), .phy_enable(phy_enable), .full_speed(full_speed));
`default_nettype wire

/* File: tb/ufx_host_model.sv */
/*
 * Host end of the cable: resolves D+ and D- from device drive, host drive
 * and pull-ups against the host's pull-downs.
 */
`timescale 1ns/1ps
`default_nettype none
module ufx_host_model (
    // Device side
    input  wire logic pullup_dplus,
    input  wire logic pullup_dminus,
    input  wire logic dplus_out,
    input  wire logic dplus_oe,
    input  wire logic dminus_out,
    input  wire logic dminus_oe,
    // Host drive
    input  wire logic host_en,
    input  wire logic host_dp,
    input  wire logic host_dm,
    // Line levels
    output logic      dplus_in,
    output logic      dminus_in
);
    // Forced drive, else host drive, else pull-up or the host's pull-down
    assign dplus_in = dplus_oe ? dplus_out : (host_en ? host_dp : pullup_dplus);
    assign dminus_in = dminus_oe ? dminus_out : (host_en ? host_dm : pullup_dminus);
endmodule
`default_nettype wire

/* File: tb/usb_function_xcvr_indirect_access_test.sv */
/*
 * Self-checking bench for ufx_front with the host line model.
 * The core register file is a small array indexed by core_addr.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_function_xcvr_indirect_access_test
    import ufx_pkg::*;
;
    typedef struct packed {
        logic [7:0] ctl;
        logic       vbus;
        logic [2:0] host;
        logic [7:0] pins;
        logic [2:0] stat;
    } ufx_row_t;
    logic       clk, rstn, sfr_wr, sfr_rd, core_wr, core_rd, vbus_present;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, core_wdata, core_rdata, d;
    logic [5:0] core_addr;
    logic [3:0] endpoint_select, endpoint_target_onehot;
    logic       dplus_in, dminus_in, dplus_out, dplus_oe, dminus_out, dminus_oe;
    logic       pullup_dplus, pullup_dminus, phy_enable, full_speed, host_en, host_dp, host_dm;
    logic [7:0] mem [64];
    int         n_tests = 0;
    int         miscompares = 0;
    logic [7:0] regs [4] = '{UFX_SFR_XCVR, UFX_SFR_ADDR, UFX_SFR_DATA, 8'h55};
    ufx_row_t   rows [9] = '{'{8'hE0, 1'b1, 3'h0, 8'hB0, 3'h6}, '{8'hA0, 1'b0, 3'h0, 8'h10, 3'h0},
        '{8'hC0, 1'b1, 3'h0, 8'h60, 3'h1}, '{8'h48, 1'b1, 3'h0, 8'h2E, 3'h6},
        '{8'h50, 1'b1, 3'h0, 8'h2B, 3'h1}, '{8'h58, 1'b1, 3'h0, 8'h2A, 3'h0},
        '{8'h98, 1'b1, 3'h0, 8'h40, 3'h1}, '{8'h40, 1'b1, 3'h5, 8'h20, 3'h1},
        '{8'h00, 1'b1, 3'h6, 8'h00, 3'h2}};
    ufx_front dut (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .core_addr(core_addr),
        .core_wr(core_wr), .core_rd(core_rd), .core_wdata(core_wdata), .core_rdata(core_rdata),
        .endpoint_select(endpoint_select), .endpoint_target_onehot(endpoint_target_onehot),
        .vbus_present(vbus_present), .dplus_in(dplus_in), .dminus_in(dminus_in),
        .dplus_out(dplus_out), .dplus_oe(dplus_oe), .dminus_out(dminus_out),
        .dminus_oe(dminus_oe), .pullup_dplus(pullup_dplus), .pullup_dminus(pullup_dminus),
        .phy_enable(phy_enable), .full_speed(full_speed));
    ufx_host_model host (.pullup_dplus(pullup_dplus), .pullup_dminus(pullup_dminus),
        .dplus_out(dplus_out), .dplus_oe(dplus_oe), .dminus_out(dminus_out),
        .dminus_oe(dminus_oe), .host_en(host_en), .host_dp(host_dp), .host_dm(host_dm),
        .dplus_in(dplus_in), .dminus_in(dminus_in));
    // Core register file, clocked writes and combinational reads
    assign core_rdata = mem[core_addr];
    always @(posedge clk) if (core_wr) mem[core_addr] <= core_wdata;
    // Free-running clock, never stopped around accesses
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(posedge clk);
        v = sfr_rdata;
    endtask
    // Poll busy with a bound before touching the data register
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h80;
        for (int k = 0; k < 20 && s[7] !== 1'b0; k++) sfr_read(UFX_SFR_ADDR, s);
        check({7'h00, s[7]}, 8'h00);
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Cut a hang short
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        close_out();
    end
    // Reset, transceiver rows, then the indirect port
    initial
    begin
        rstn = 1'b0;
        {sfr_wr, sfr_rd, vbus_present, host_en, host_dp, host_dm} = '0;
        {sfr_addr, sfr_wdata} = 16'h0000;
        foreach (mem[i]) mem[i] = 8'h5A ^ 8'(i);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (regs[i])
        begin
            sfr_read(regs[i], d);
            check(d, 8'h00);
        end
        foreach (rows[i])
        begin
            @(posedge clk);
            vbus_present <= rows[i].vbus;
            {host_en, host_dp, host_dm} <= rows[i].host;
            sfr_write(UFX_SFR_XCVR, rows[i].ctl);
            repeat (6) @(posedge clk);
            check({pullup_dplus, pullup_dminus, phy_enable, full_speed, dplus_oe,
                dplus_out & dplus_oe, dminus_oe, dminus_out & dminus_oe}, rows[i].pins);
            sfr_read(UFX_SFR_XCVR, d);
            check(d, {rows[i].ctl[7:3], rows[i].stat});
        end
        sfr_write(UFX_SFR_ADDR, 8'h85);
        sfr_read(UFX_SFR_ADDR, d);
        check(d, 8'h85);
        wait_idle();
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'h5F);
        mem[6] <= 8'hA5;
        sfr_write(UFX_SFR_ADDR, 8'h06);
        repeat (4) @(posedge clk);
        wait_idle();
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'h5F);
        sfr_write(UFX_SFR_ADDR, 8'hC6);
        wait_idle();
        mem[6] <= 8'h3C;
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'hA5);
        wait_idle();
        sfr_read(UFX_SFR_ADDR, d);
        check(d, 8'h46);
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'h3C);
        wait_idle();
        sfr_write(UFX_SFR_ADDR, 8'h10);
        sfr_write(UFX_SFR_DATA, 8'h77);
        sfr_write(UFX_SFR_ADDR, 8'h90);
        wait_idle();
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'h77);
        sfr_write(UFX_SFR_ADDR, 8'h0F);
        sfr_write(UFX_SFR_DATA, 8'hF2);
        repeat (3) @(posedge clk);
        check({endpoint_select, endpoint_target_onehot}, 8'h24);
        sfr_write(UFX_SFR_ADDR, 8'h8F);
        wait_idle();
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'h02);
        sfr_write(UFX_SFR_DATA, 8'h07);
        repeat (3) @(posedge clk);
        check({endpoint_select, endpoint_target_onehot}, 8'h70);
        // Mid-run reset clears index, address and data registers
        rstn <= 1'b0;
        @(posedge clk);
        check({endpoint_select, endpoint_target_onehot}, 8'h00);
        rstn <= 1'b1;
        sfr_read(UFX_SFR_ADDR, d);
        check(d, 8'h00);
        sfr_read(UFX_SFR_DATA, d);
        check(d, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
